// file: core/mvpc_pkg.sv
// Constants, opcodes and helpers for the move / port-control executor
// Function
// [RQ1] OR-immediate ORs the 8-bit immediate into the work register.
// [RQ2] Port-control load copies work register to selectors 5-9, 12-15; no flags.
// [RQ3] Port-control read copies selected register to work register; no flags.
// [RQ4] Store copies work register to file register 0-63; no flags.
// [RQ5] Load-immediate places the 8-bit immediate into the work register; no flags.
// [RQ6] Program image encodes don't-care bits of load-immediate as zeros.
// [RQ7] Move-file reads file register; destination bit selects work or same register.
// [RQ8] Move-file updates zero flag from moved value for either destination.
// [RQ9] Every instruction here completes in one cycle without stall.
package mvpc_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FADDR_W    = 6;
   localparam int unsigned SEL_W      = 4;
   localparam int unsigned FILE_DEPTH = 64;
   localparam int unsigned PCTL_DEPTH = 16;

   localparam logic [7:0] WORK_RST  = 8'h00;
   localparam logic [7:0] PCTL_RST  = 8'hFF;
   localparam logic [7:0] FILE_RST  = 8'h00;
   localparam logic       ZERO_RST  = 1'b0;
   localparam logic       DEST_WORK = 1'b0;

   typedef enum logic [2:0]
   {
      MVPC_OR_IMM    = 3'h0,
      MVPC_PCTL_LOAD = 3'h1,
      MVPC_PCTL_READ = 3'h3,
      MVPC_STORE     = 3'h2,
      MVPC_LOAD_IMM  = 3'h6,
      MVPC_MOVE_FILE = 3'h7
   } mvpc_op_t;

   // Selector set shared by both port-control forms
   function automatic logic sel_valid(input logic [3:0] sel);
      begin
         sel_valid = ((sel >= 4'h5) && (sel <= 4'h9)) || (sel >= 4'hC);
      end
   endfunction
endpackage

// file: core/mvpc_result.sv
// Result and zero-flag selection for one executed instruction
module mvpc_result
(
   input  wire mvpc_pkg::mvpc_op_t op,
   input  wire logic [7:0]         work,
   input  wire logic [7:0]         imm,
   input  wire logic [7:0]         file_q,
   input  wire logic [7:0]         pctl_q,
   output logic      [7:0]         result,
   output logic                    zero
);
   always_comb
   begin
      result = work;
      unique case (op)
         // [RQ1] OR into work
         mvpc_pkg::MVPC_OR_IMM:    result = work | imm;
         // [RQ3] Read control reg
         mvpc_pkg::MVPC_PCTL_READ: result = pctl_q;
         // [RQ5] Immediate to work
         mvpc_pkg::MVPC_LOAD_IMM:  result = imm;
         // [RQ7] File value moved
         mvpc_pkg::MVPC_MOVE_FILE: result = file_q;
         default:                  result = work;
      endcase
      zero = (result == 8'h00);
   end
endmodule

// file: core/mvpc_exec.sv
// Executor for OR-immediate, port-control, store, load-immediate and move instructions
module mvpc_exec
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               op_valid,
   input  wire mvpc_pkg::mvpc_op_t op,
   input  wire logic [7:0]         imm,
   input  wire logic [5:0]         file_addr,
   input  wire logic               dest,
   input  wire logic [3:0]         pctl_sel,
   input  wire logic [5:0]         peek_addr,
   output logic      [7:0]         work_register,
   output logic                    zero_flag,
   output logic                    done,
   output logic                    bad_sel,
   output logic      [7:0]         peek_data
);
   typedef struct packed
   {
      logic [7:0] work_r;
      logic       zero_r;
      logic       done_r;
      logic       bad_r;
      logic [7:0] peek_r;
   } mvpc_state_t;

   mvpc_state_t state_r;
   mvpc_state_t state_nxt;
   // Arrays kept apart from the struct: a packed copy would be 640 bits wide
   logic [7:0]  file_mem [mvpc_pkg::FILE_DEPTH];
   logic [7:0]  pctl_mem [mvpc_pkg::PCTL_DEPTH];
   logic [7:0]  result;
   logic        res_zero;
   logic        sel_ok;
   logic        file_we;
   logic [7:0]  file_wd;
   logic        pctl_we;

   assign sel_ok = mvpc_pkg::sel_valid(pctl_sel);

   mvpc_result mvpc_result_i
   (
      .op     (op),
      .work   (state_r.work_r),
      .imm    (imm),
      .file_q (file_mem[file_addr]),
      .pctl_q (pctl_mem[pctl_sel]),
      .result (result),
      .zero   (res_zero)
   );

   always_comb
   begin
      state_nxt        = state_r;
      state_nxt.done_r = 1'b0;
      state_nxt.bad_r  = 1'b0;
      state_nxt.peek_r = file_mem[peek_addr];
      file_we          = 1'b0;
      file_wd          = state_r.work_r;
      pctl_we          = 1'b0;
      if (op_valid)
      begin
         // [RQ9] Single-cycle completion
         state_nxt.done_r = 1'b1;
         unique case (op)
            mvpc_pkg::MVPC_OR_IMM:
            begin
               state_nxt.work_r = result;
               state_nxt.zero_r = res_zero;
            end
            mvpc_pkg::MVPC_PCTL_LOAD:
            begin
               // [RQ2] Guarded control write
               pctl_we         = sel_ok;
               state_nxt.bad_r = !sel_ok;
            end
            mvpc_pkg::MVPC_PCTL_READ:
            begin
               // [RQ3] Guarded control read
               if (sel_ok)
               begin
                  state_nxt.work_r = result;
               end
               state_nxt.bad_r = !sel_ok;
            end
            mvpc_pkg::MVPC_STORE:
            begin
               // [RQ4] Work to file
               file_we = 1'b1;
            end
            mvpc_pkg::MVPC_LOAD_IMM:
            begin
               // [RQ6] Encoding zeros unused: only the immediate field is read
               state_nxt.work_r = result;
            end
            mvpc_pkg::MVPC_MOVE_FILE:
            begin
               // [RQ7] Destination select
               if (dest == mvpc_pkg::DEST_WORK)
               begin
                  state_nxt.work_r = result;
               end
               else
               begin
                  file_we = 1'b1;
                  file_wd = result;
               end
               // [RQ8] Zero from moved value
               state_nxt.zero_r = res_zero;
            end
            default:
            begin
               state_nxt.done_r = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r.work_r <= mvpc_pkg::WORK_RST;
         state_r.zero_r <= mvpc_pkg::ZERO_RST;
         state_r.done_r <= 1'b0;
         state_r.bad_r  <= 1'b0;
         state_r.peek_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Memories reset too, so a test never reads X from an unwritten entry
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < mvpc_pkg::FILE_DEPTH; i++)
         begin
            file_mem[i] <= mvpc_pkg::FILE_RST;
         end
         for (int j = 0; j < mvpc_pkg::PCTL_DEPTH; j++)
         begin
            pctl_mem[j] <= mvpc_pkg::PCTL_RST;
         end
      end
      else
      begin
         if (file_we)
         begin
            file_mem[file_addr] <= file_wd;
         end
         if (pctl_we)
         begin
            pctl_mem[pctl_sel] <= state_r.work_r;
         end
      end
   end

   assign work_register = state_r.work_r;
   assign zero_flag     = state_r.zero_r;
   assign done          = state_r.done_r;
   assign bad_sel       = state_r.bad_r;
   assign peek_data     = state_r.peek_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_OR_IMM: assert property (op_valid && op == mvpc_pkg::MVPC_OR_IMM |=> // [RQ1]
      work_register == ($past(work_register) | $past(imm)))
      else $error("OR immediate result wrong");
   AST_PCTL_LOAD: assert property (op_valid && op == mvpc_pkg::MVPC_PCTL_LOAD |=> // [RQ2]
      zero_flag == $past(zero_flag) && work_register == $past(work_register) && bad_sel == !$past(sel_ok))
      else $error("Port control load changed state or flagged wrongly");
   AST_PCTL_RT: assert property (op_valid && op == mvpc_pkg::MVPC_PCTL_LOAD && sel_ok ##1 // [RQ3]
      op_valid && op == mvpc_pkg::MVPC_PCTL_READ && pctl_sel == $past(pctl_sel)
      |=> work_register == $past(work_register, 2) && zero_flag == $past(zero_flag))
      else $error("Port control read did not return loaded value");
   AST_PCTL_BAD: assert property (op_valid && op == mvpc_pkg::MVPC_PCTL_READ && !sel_ok |=> // [RQ3]
      bad_sel && $stable(work_register))
      else $error("Invalid selector read altered work register");
   AST_STORE: assert property (op_valid && op == mvpc_pkg::MVPC_STORE ##1 // [RQ4]
      peek_addr == $past(file_addr) && !(op_valid && op == mvpc_pkg::MVPC_STORE) |=>
      peek_data == $past(work_register, 2))
      else $error("Store did not reach file register");
   AST_STORE_FLAGS: assert property (op_valid && op == mvpc_pkg::MVPC_STORE |=> // [RQ4]
      $stable(zero_flag) && $stable(work_register))
      else $error("Store changed work register or flag");
   AST_LOAD_IMM: assert property (op_valid && op == mvpc_pkg::MVPC_LOAD_IMM |=> // [RQ5]
      work_register == $past(imm) && $stable(zero_flag))
      else $error("Load immediate wrong");
   AST_MOVE_WORK: assert property (op_valid && op == mvpc_pkg::MVPC_MOVE_FILE && !dest |=> // [RQ7]
      work_register == $past(file_mem[file_addr]))
      else $error("Move to work register wrong");
   AST_MOVE_ZERO: assert property (op_valid && op == mvpc_pkg::MVPC_MOVE_FILE |=> // [RQ8]
      zero_flag == ($past(file_mem[file_addr]) == 8'h00))
      else $error("Move did not set zero flag from value");
   AST_ONE_CYCLE: assert property (op_valid |=> done ##0 (!$past(op_valid, 2) || done)) // [RQ9]
      else $error("Instruction did not complete in one cycle");
   AST_IDLE: assert property (!op_valid |=> // [RQ9]
      !done && !bad_sel && $stable(work_register) && $stable(zero_flag))
      else $error("Idle cycle changed state");
   AST_MOVE_KEEP: assert property (op_valid && op == mvpc_pkg::MVPC_MOVE_FILE && dest |=> // [RQ7]
      $stable(work_register))
      else $error("Move back to file register altered work register");
   AST_READ_FLAG: assert property (op_valid && op == mvpc_pkg::MVPC_PCTL_READ |=> // [RQ3]
      $stable(zero_flag))
      else $error("Port control read changed zero flag");
   AST_OR_ZERO: assert property (op_valid && op == mvpc_pkg::MVPC_OR_IMM |=> // [RQ1]
      zero_flag == (work_register == 8'h00))
      else $error("OR immediate zero flag wrong");

   COV_MOVE_SELF: cover property (op_valid && op == mvpc_pkg::MVPC_MOVE_FILE && dest ##1 zero_flag);
   COV_BAD_SEL: cover property (op_valid && op == mvpc_pkg::MVPC_PCTL_LOAD && !sel_ok);
   COV_BACK2BACK: cover property (op_valid && op == mvpc_pkg::MVPC_STORE ##1
      op_valid && op == mvpc_pkg::MVPC_MOVE_FILE);
   COV_PCTL_RT: cover property (op_valid && op == mvpc_pkg::MVPC_PCTL_LOAD && sel_ok ##1
      op_valid && op == mvpc_pkg::MVPC_PCTL_READ);
endmodule

// file: bench/tb_mvpc_exec.sv
// Random self-checking testbench for the move / port-control executor
module tb_mvpc_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk;
   logic               rst;
   logic               op_valid;
   mvpc_pkg::mvpc_op_t op;
   logic [7:0]         imm;
   logic [5:0]         file_addr;
   logic               dest;
   logic [3:0]         pctl_sel;
   logic [5:0]         peek_addr;
   logic [7:0]         work_register;
   logic               zero_flag;
   logic               done;
   logic               bad_sel;
   logic [7:0]         peek_data;
   logic [7:0]         m_work;
   logic               m_zero;
   logic [7:0]         m_file [64];
   logic [7:0]         m_pctl [16];
   int                 n_fail;
   int                 n_tests;
   mvpc_pkg::mvpc_op_t ops [6];

   mvpc_exec mvpc_exec_i (.clk(clk), .rst(rst), .op_valid(op_valid), .op(op), .imm(imm),
      .file_addr(file_addr), .dest(dest), .pctl_sel(pctl_sel), .peek_addr(peek_addr),
      .work_register(work_register), .zero_flag(zero_flag), .done(done), .bad_sel(bad_sel),
      .peek_data(peek_data));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic sel_ok(input logic [3:0] s);
      return s inside {[4'h5:4'h9], [4'hC:4'hF]};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset;
      rst = 1'b1;
      op_valid = 1'b0;
      m_work = 8'h00;
      m_zero = 1'b0;
      foreach (m_file[k]) m_file[k] = 8'h00;
      foreach (m_pctl[k]) m_pctl[k] = 8'hFF;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(work_register, 8'h00);
      chk({7'h00, zero_flag}, 8'h00);
      chk({7'h00, done}, 8'h00);
      chk({7'h00, bad_sel}, 8'h00);
      chk(peek_data, 8'h00);
   endtask

   task automatic step(input logic v, input mvpc_pkg::mvpc_op_t o, input logic [7:0] i,
                       input logic [5:0] fa, input logic d, input logic [3:0] s);
      logic [7:0] e_peek;
      logic       e_bad;
      op_valid = v;
      op = o;
      imm = i;
      file_addr = fa;
      dest = d;
      pctl_sel = s;
      e_peek = m_file[peek_addr];
      e_bad = 1'b0;
      if (v)
      begin
         case (o)
            mvpc_pkg::MVPC_OR_IMM:
            begin
               m_work = m_work | i;
               m_zero = (m_work == 8'h00);
            end
            mvpc_pkg::MVPC_PCTL_LOAD:
            begin
               if (sel_ok(s))
                  m_pctl[s] = m_work;
               else
                  e_bad = 1'b1;
            end
            mvpc_pkg::MVPC_PCTL_READ:
            begin
               if (sel_ok(s))
                  m_work = m_pctl[s];
               else
                  e_bad = 1'b1;
            end
            mvpc_pkg::MVPC_STORE:
               m_file[fa] = m_work;
            mvpc_pkg::MVPC_LOAD_IMM:
               m_work = i;
            default:
            begin
               m_zero = (m_file[fa] == 8'h00);
               if (!d)
                  m_work = m_file[fa];
            end
         endcase
      end
      @(posedge clk);
      #1;
      chk(work_register, m_work);
      chk({7'h00, zero_flag}, {7'h00, m_zero});
      chk({7'h00, done}, {7'h00, v});
      chk({7'h00, bad_sel}, {7'h00, e_bad});
      chk(peek_data, e_peek);
      peek_addr = 6'($urandom);
   endtask

   initial
   begin
      #(40 * 20000);
      n_fail++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(48822));
      ops = '{mvpc_pkg::MVPC_OR_IMM, mvpc_pkg::MVPC_PCTL_LOAD, mvpc_pkg::MVPC_PCTL_READ,
              mvpc_pkg::MVPC_STORE, mvpc_pkg::MVPC_LOAD_IMM, mvpc_pkg::MVPC_MOVE_FILE};
      n_fail = 0;
      n_tests = 0;
      op = mvpc_pkg::MVPC_OR_IMM;
      imm = 8'h00;
      file_addr = 6'h00;
      dest = 1'b0;
      pctl_sel = 4'h0;
      peek_addr = 6'h00;
      do_reset();
      // Zero flag set and cleared by OR, then set by a move back to the file register
      step(1'b1, mvpc_pkg::MVPC_OR_IMM, 8'h00, 6'h00, 1'b0, 4'h0);
      step(1'b1, mvpc_pkg::MVPC_OR_IMM, 8'h81, 6'h00, 1'b0, 4'h0);
      step(1'b1, mvpc_pkg::MVPC_MOVE_FILE, 8'h00, 6'h3F, 1'b1, 4'h0);
      // Store then watch the same file register on the peek port
      step(1'b1, mvpc_pkg::MVPC_LOAD_IMM, 8'h5A, 6'h00, 1'b0, 4'h0);
      step(1'b1, mvpc_pkg::MVPC_STORE, 8'h00, 6'h03, 1'b0, 4'h0);
      peek_addr = 6'h03;
      step(1'b1, mvpc_pkg::MVPC_OR_IMM, 8'h00, 6'h00, 1'b0, 4'h0);
      // Every selector, valid and invalid, written then read back
      for (int s = 0; s < 16; s++)
      begin
         step(1'b1, mvpc_pkg::MVPC_PCTL_READ, 8'h00, 6'h00, 1'b0, 4'(s));
         step(1'b1, mvpc_pkg::MVPC_LOAD_IMM, 8'(s) ^ 8'hA5, 6'h00, 1'b0, 4'h0);
         step(1'b1, mvpc_pkg::MVPC_PCTL_LOAD, 8'h00, 6'h00, 1'b0, 4'(s));
         step(1'b1, mvpc_pkg::MVPC_PCTL_READ, 8'h00, 6'h00, 1'b0, 4'(s));
         step(1'b1, mvpc_pkg::MVPC_LOAD_IMM, 8'h00, 6'h00, 1'b0, 4'h0);
         step(1'b1, mvpc_pkg::MVPC_PCTL_READ, 8'h00, 6'h00, 1'b0, 4'(s));
      end
      for (int r = 0; r < 2; r++)
      begin
         repeat (1500)
            step(($urandom % 4) != 0, ops[$urandom % 6], 8'($urandom), 6'($urandom),
                 1'($urandom), 4'($urandom));
         // Reset in mid-run restores all state
         do_reset();
      end
      give_verdict();
   end
endmodule
